// ==== design/disk_ctl_pkg.sv ====
package disk_ctl_pkg;

  // ------------------------------------------------------------
  // Clock and timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_KHZ = 125000;          // 125 MHz system clock
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned TIMEOUT_MS = 2000;         // Operation must finish within 2 s
  localparam int unsigned TIMEOUT_CYCLES_DEF = TIMEOUT_MS * CLK_KHZ;
  localparam int unsigned TIMEOUT_W = 28;            // Holds 250e6
  localparam int unsigned DATA_RATE_NS = 13000;      // Break answer deadline, 13 us
  localparam int unsigned DATA_RATE_CYCLES = DATA_RATE_NS / CLK_PERIOD_NS;  // Longest time: round down
  localparam int unsigned RATE_W = 11;
  localparam int unsigned SECTOR_PERIOD_US = 5000;   // Sector counter step, 5 ms
  localparam int unsigned SECTOR_CYCLES_DEF = SECTOR_PERIOD_US * (CLK_KHZ / 1000);
  localparam int unsigned SECTOR_W = 20;

  // ------------------------------------------------------------
  // Instruction codes (low two octal digits of the IOT)
  // ------------------------------------------------------------
  localparam logic [5:0] IOT_STORE_CTL = 6'h1a;      // 6732
  localparam logic [5:0] IOT_LOAD_READ = 6'h1b;      // 6733
  localparam logic [5:0] IOT_FETCH_POS = 6'h1c;      // 6734
  localparam logic [5:0] IOT_LOAD_WRITE = 6'h1d;     // 6735
  localparam logic [5:0] IOT_FETCH_CTL = 6'h1e;      // 6736
  localparam logic [5:0] IOT_LOAD_VERIFY = 6'h1f;    // 6737
  localparam logic [5:0] IOT_FETCH_COND = 6'h21;     // 6741
  localparam logic [5:0] IOT_CLEAR_COND = 6'h22;     // Status clear

  // ------------------------------------------------------------
  // Control word fields
  // ------------------------------------------------------------
  localparam int unsigned CW_SEEK_ONLY = 4;
  localparam int unsigned CW_EMA2 = 8;
  localparam int unsigned CW_DRV_LO = 9;
  localparam int unsigned CW_DRV_HI = 10;
  localparam int unsigned CW_HALF = 11;
  localparam logic [11:0] CW_RESET = 12'h000;

  // ------------------------------------------------------------
  // Condition word bits
  // ------------------------------------------------------------
  localparam int unsigned SB_ERROR = 0;
  localparam int unsigned SB_DONE = 1;
  localparam int unsigned SB_BUSY_ERR = 2;
  localparam int unsigned SB_TIMEOUT = 3;
  localparam int unsigned SB_PARITY = 4;
  localparam int unsigned SB_RATE = 5;
  localparam int unsigned SB_TRACK = 6;
  localparam int unsigned SB_BAD = 7;
  localparam int unsigned SB_LOCK = 8;
  localparam int unsigned SB_CAP = 9;
  localparam int unsigned SB_SELECT = 10;
  localparam int unsigned SB_BUSY = 11;
  localparam logic [11:0] COND_RESET = 12'h000;

  // ------------------------------------------------------------
  // Disk address word and header word fields
  // ------------------------------------------------------------
  localparam int unsigned AD_TRACK_HI = 11;
  localparam int unsigned AD_TRACK_LO = 5;
  localparam int unsigned AD_SURFACE = 4;
  localparam int unsigned AD_SECTOR_HI = 3;
  localparam logic [3:0] SECTOR_LAST = 4'hf;         // Octal 17
  localparam int unsigned HDR2_PROTECT = 0;
  localparam int unsigned HDR2_BAD_LO = 1;
  localparam int unsigned HDR2_BAD_HI = 5;

  // Operation chosen by the load-address instruction
  typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_VERIFY} op_e;

  // One header word from the selected drive
  typedef struct packed {
    logic valid;        // Word present this cycle
    logic second;       // 0 first header word, 1 second
    logic [11:0] word;
  } header_beat_s;

  // Readiness of the four drives
  typedef struct packed {
    logic [3:0] present;
    logic [3:0] ready;
  } drive_state_s;

  // Field extraction, used on both address and header words
  function automatic logic [6:0] track_of(input logic [11:0] w);
    return w[AD_TRACK_HI:AD_TRACK_LO];
  endfunction

  function automatic logic [3:0] sector_of(input logic [11:0] w);
    return w[AD_SECTOR_HI:0];
  endfunction

endpackage

// ==== design/position_counters.sv ====
`timescale 1ns/1ps
module position_counters import disk_ctl_pkg::*; #(
  parameter int unsigned SECTOR_CYCLES = SECTOR_CYCLES_DEF
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  // Track and surface load
  input wire logic load,
  input wire logic [11:0] load_word,
  // Live track, surface, sector
  output logic [11:0] position
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  logic [SECTOR_W-1:0] tick_reg, tick_next;  // Cycles into current sector
  logic [11:0] pos_reg, pos_next;            // Track, surface, sector

  // Sector steps every period; track and surface follow the last load
  always_comb begin
    tick_next = tick_reg + SECTOR_W'(1);
    pos_next = pos_reg;
    if (tick_reg == SECTOR_W'(SECTOR_CYCLES - 1)) begin
      tick_next = '0;
      pos_next[AD_SECTOR_HI:0] = sector_of(pos_reg) + 4'h1;  // Wraps after octal 17
    end
    if (load) begin
      pos_next[AD_TRACK_HI:AD_SURFACE] = load_word[AD_TRACK_HI:AD_SURFACE];
    end
  end

  // Registers only
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tick_reg <= '0;
      pos_reg <= '0;
    end else if (ce) begin
      tick_reg <= tick_next;
      pos_reg <= pos_next;
    end
  end

  assign position = pos_reg;

endmodule

// ==== design/disk_command_status_control.sv ====
`timescale 1ns/1ps
module disk_command_status_control import disk_ctl_pkg::*; #(
  parameter int unsigned TIMEOUT_CYCLES = TIMEOUT_CYCLES_DEF,
  parameter int unsigned SECTOR_CYCLES = SECTOR_CYCLES_DEF
) (
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  // Processor instruction side
  input wire logic iot_strobe,
  input wire logic [5:0] iot_code,
  input wire logic [11:0] accumulator_in,
  output logic [11:0] accumulator_out,
  output logic accumulator_load,
  // Drive selection and seek
  input wire drive_state_s drives,
  input wire logic protect_switch,
  input wire logic seek_done,
  input wire logic seek_fault,
  output logic seek_start,
  output logic [6:0] seek_track,
  output logic [1:0] drive_select,
  output logic head_surface,
  output logic ext_addr_bit2,
  output logic track_half,
  // Header words and data transfer
  input wire header_beat_s hdr,
  input wire logic break_grant,
  input wire logic read_error,
  input wire logic next_sector_req,
  input wire logic transfer_end,
  output logic break_request,
  output logic write_gate
);

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  typedef enum logic [2:0] {ST_IDLE, ST_SEEK, ST_HEADER1, ST_HEADER2, ST_TRANSFER} state_e;

  state_e state_reg, state_next;                 // Sequencer
  op_e op_reg, op_next;                          // Read, write or verify
  logic [11:0] operation_control_word_reg, operation_control_word_next;
  logic [11:0] condition_flags_word_reg, condition_flags_word_next;
  logic [11:0] addr_reg, addr_next;              // Track, surface, sector wanted
  logic [11:0] acc_reg, acc_next;                // Word handed back to processor
  logic acc_load_reg, acc_load_next;
  logic seek_start_reg, seek_start_next;
  logic break_reg, break_next;
  logic wgate_reg, wgate_next;
  logic [TIMEOUT_W-1:0] tmo_reg, tmo_next;       // Time since start
  logic [RATE_W-1:0] rate_reg, rate_next;        // Time break waits
  logic [11:0] err_set;                          // Error events this cycle
  logic done_set;                                // Termination this cycle
  logic clear_cond;                              // Status clear instruction
  logic busy;
  logic [11:0] position;                         // Live counters
  logic [1:0] sel;                               // Drive named by control word

  // ------------------------------------------------------------
  // Live position counters
  // ------------------------------------------------------------
  position_counters #(.SECTOR_CYCLES(SECTOR_CYCLES)) u_pos (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .load(seek_start_next),
    .load_word(addr_next),
    .position(position)
  );

  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    op_next = op_reg;
    operation_control_word_next = operation_control_word_reg;
    addr_next = addr_reg;
    acc_next = acc_reg;
    acc_load_next = 1'b0;
    seek_start_next = 1'b0;
    break_next = break_reg;
    wgate_next = wgate_reg;
    err_set = '0;
    done_set = 1'b0;
    clear_cond = 1'b0;
    busy = (state_reg != ST_IDLE);
    sel = operation_control_word_reg[CW_DRV_HI:CW_DRV_LO];
    tmo_next = busy ? tmo_reg + TIMEOUT_W'(1) : '0;
    rate_next = (break_reg && !break_grant) ? rate_reg + RATE_W'(1) : '0;

    // Instructions from the processor
    if (iot_strobe) begin
      case (iot_code)
        IOT_STORE_CTL: begin
          if (busy) begin
            err_set[SB_BUSY_ERR] = 1'b1;
          end else begin
            operation_control_word_next = accumulator_in;
          end
        end
        IOT_LOAD_READ, IOT_LOAD_WRITE, IOT_LOAD_VERIFY: begin
          if (busy) begin
            err_set[SB_BUSY_ERR] = 1'b1;
          end else begin
            addr_next = accumulator_in;
            op_next = (iot_code == IOT_LOAD_READ) ? OP_READ :
                      (iot_code == IOT_LOAD_WRITE) ? OP_WRITE : OP_VERIFY;
            state_next = ST_SEEK;
            seek_start_next = 1'b1;
            tmo_next = '0;
            // Refuse a drive that is missing or not ready
            if (!drives.present[sel] || !drives.ready[sel]) begin
              err_set[SB_SELECT] = 1'b1;
            end
          end
        end
        IOT_FETCH_POS: begin
          acc_next = position;
          acc_load_next = 1'b1;
        end
        IOT_FETCH_CTL: begin
          acc_next = operation_control_word_reg;
          acc_load_next = 1'b1;
        end
        IOT_FETCH_COND: begin
          acc_next = condition_flags_word_reg;
          acc_load_next = 1'b1;
        end
        IOT_CLEAR_COND: clear_cond = 1'b1;
        default: ;                                       // Other devices' codes
      endcase
    end

    // Operation sequencer
    unique case (state_reg)
      ST_IDLE: ;
      ST_SEEK: begin
        if (seek_fault) begin
          err_set[SB_SELECT] = 1'b1;
        end else if (seek_done) begin
          if (operation_control_word_reg[CW_SEEK_ONLY]) begin
            state_next = ST_IDLE;
          end else begin
            state_next = ST_HEADER1;
          end
        end
      end
      ST_HEADER1: begin
        if (hdr.valid && !hdr.second) begin
          if (track_of(hdr.word) != track_of(addr_reg)) begin
            err_set[SB_TRACK] = 1'b1;
          end else if (sector_of(hdr.word) == sector_of(addr_reg)) begin
            state_next = ST_HEADER2;
          end
          // Otherwise wait for the next sector's header
        end
      end
      ST_HEADER2: begin
        if (hdr.valid && hdr.second) begin
          // Protect bit is only looked at for writes; bits 6-11 unused
          if (op_reg == OP_WRITE && hdr.word[HDR2_PROTECT] && protect_switch) begin
            err_set[SB_LOCK] = 1'b1;
          end else if (|hdr.word[HDR2_BAD_HI:HDR2_BAD_LO]) begin
            err_set[SB_BAD] = 1'b1;
          end else begin
            state_next = ST_TRANSFER;
            break_next = 1'b1;
            wgate_next = (op_reg == OP_WRITE);
          end
        end
      end
      ST_TRANSFER: begin
        if (read_error && op_reg != OP_WRITE) begin
          err_set[SB_PARITY] = 1'b1;
        end else if (transfer_end) begin
          state_next = ST_IDLE;
        end else if (next_sector_req) begin
          if (sector_of(addr_reg) == SECTOR_LAST) begin
            err_set[SB_CAP] = 1'b1;
          end else begin
            addr_next[AD_SECTOR_HI:0] = sector_of(addr_reg) + 4'h1;
            state_next = ST_HEADER1;
            break_next = 1'b0;
            wgate_next = 1'b0;
          end
        end
      end
    endcase

    // Deadlines
    if (break_reg && !break_grant && rate_reg == RATE_W'(DATA_RATE_CYCLES - 1)) begin
      err_set[SB_RATE] = 1'b1;
    end
    if (busy && tmo_reg == TIMEOUT_W'(TIMEOUT_CYCLES - 1)) begin
      err_set[SB_TIMEOUT] = 1'b1;
    end

    // Any error halts the operation
    if (|err_set) begin
      state_next = ST_IDLE;
      done_set = 1'b1;
    end
    if (busy && state_next == ST_IDLE) begin
      done_set = 1'b1;
      break_next = 1'b0;
      wgate_next = 1'b0;
    end

    // Condition word: events set, clear loses to a same-cycle set
    condition_flags_word_next = clear_cond ? COND_RESET : condition_flags_word_reg;
    condition_flags_word_next = condition_flags_word_next | err_set;
    if (|err_set) begin
      condition_flags_word_next[SB_ERROR] = 1'b1;
    end
    if (done_set) begin
      condition_flags_word_next[SB_DONE] = 1'b1;
    end
    condition_flags_word_next[SB_BUSY] = (state_next != ST_IDLE);
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      op_reg <= OP_READ;
      operation_control_word_reg <= CW_RESET;
      condition_flags_word_reg <= COND_RESET;
      addr_reg <= '0;
      acc_reg <= '0;
      acc_load_reg <= 1'b0;
      seek_start_reg <= 1'b0;
      break_reg <= 1'b0;
      wgate_reg <= 1'b0;
      tmo_reg <= '0;
      rate_reg <= '0;
    end else if (ce) begin
      state_reg <= state_next;
      op_reg <= op_next;
      operation_control_word_reg <= operation_control_word_next;
      condition_flags_word_reg <= condition_flags_word_next;
      addr_reg <= addr_next;
      acc_reg <= acc_next;
      acc_load_reg <= acc_load_next;
      seek_start_reg <= seek_start_next;
      break_reg <= break_next;
      wgate_reg <= wgate_next;
      tmo_reg <= tmo_next;
      rate_reg <= rate_next;
    end
  end

  // ------------------------------------------------------------
  // Outputs, all straight from flops
  // ------------------------------------------------------------
  assign accumulator_out = acc_reg;
  assign accumulator_load = acc_load_reg;
  assign seek_start = seek_start_reg;
  assign seek_track = track_of(addr_reg);
  assign head_surface = addr_reg[AD_SURFACE];
  assign drive_select = operation_control_word_reg[CW_DRV_HI:CW_DRV_LO];
  assign ext_addr_bit2 = operation_control_word_reg[CW_EMA2];
  assign track_half = operation_control_word_reg[CW_HALF];
  assign break_request = break_reg;
  assign write_gate = wgate_reg;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_hdr2_bad;
    ce && state_reg == ST_HEADER2 && hdr.valid && hdr.second && |hdr.word[HDR2_BAD_HI:HDR2_BAD_LO]
      && !(op_reg == OP_WRITE && hdr.word[HDR2_PROTECT] && protect_switch);
  endsequence
  sequence s_halted;
    !condition_flags_word_reg[SB_BUSY] && condition_flags_word_reg[SB_DONE]
      && condition_flags_word_reg[SB_ERROR];
  endsequence

  property p_bad_sector;
    s_hdr2_bad |=> condition_flags_word_reg[SB_BAD] ##0 s_halted;
  endproperty
  a_bad_sector: assert property (p_bad_sector) else $error("bad header did not abort");

  property p_track_err;
    ce && state_reg == ST_HEADER1 && hdr.valid && !hdr.second && track_of(hdr.word) != track_of(addr_reg)
      |=> condition_flags_word_reg[SB_TRACK] && state_reg == ST_IDLE;
  endproperty
  a_track_err: assert property (p_track_err) else $error("track mismatch not flagged");

  property p_protect;
    ce && state_reg == ST_HEADER2 && op_reg == OP_WRITE && hdr.valid && hdr.second
      && hdr.word[HDR2_PROTECT] && protect_switch |=> condition_flags_word_reg[SB_LOCK] && !write_gate;
  endproperty
  a_protect: assert property (p_protect) else $error("protected write not stopped");

  property p_summary;
    |condition_flags_word_reg[SB_SELECT:SB_BUSY_ERR] |-> condition_flags_word_reg[SB_ERROR];
  endproperty
  a_summary: assert property (p_summary) else $error("summary error flag missing");

  property p_done_on_fall;
    $fell(condition_flags_word_reg[SB_BUSY]) |-> condition_flags_word_reg[SB_DONE];
  endproperty
  a_done_on_fall: assert property (p_done_on_fall) else $error("busy fell without done");

  property p_fetch_cond;
    ce && iot_strobe && iot_code == IOT_FETCH_COND
      |=> accumulator_load && accumulator_out == $past(condition_flags_word_reg);
  endproperty
  a_fetch_cond: assert property (p_fetch_cond) else $error("status readback wrong");

  property p_fetch_ctl;
    ce && iot_strobe && iot_code == IOT_FETCH_CTL
      |=> accumulator_load && accumulator_out == $past(operation_control_word_reg);
  endproperty
  a_fetch_ctl: assert property (p_fetch_ctl) else $error("control readback wrong");

  property p_seek_only;
    ce && state_reg == ST_SEEK && !seek_fault && seek_done && operation_control_word_reg[CW_SEEK_ONLY]
      |=> condition_flags_word_reg[SB_DONE] && !condition_flags_word_reg[SB_BUSY] && !break_request;
  endproperty
  a_seek_only: assert property (p_seek_only) else $error("seek only did not finish");

  property p_rate;
    ce && break_request && !break_grant && rate_reg == RATE_W'(DATA_RATE_CYCLES - 1)
      |=> condition_flags_word_reg[SB_RATE] && !break_request;
  endproperty
  a_rate: assert property (p_rate) else $error("late break not flagged");

  property p_busy_err;
    ce && iot_strobe && iot_code == IOT_STORE_CTL && state_reg != ST_IDLE
      |=> condition_flags_word_reg[SB_BUSY_ERR] && operation_control_word_reg == $past(operation_control_word_reg);
  endproperty
  a_busy_err: assert property (p_busy_err) else $error("busy instruction not flagged");

endmodule

// ==== test/disk_drive_model.sv ====
`timescale 1ns/1ps
module disk_drive_model import disk_ctl_pkg::*; (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Controller side
  input wire logic seek_start,
  input wire logic break_request,
  output logic seek_done,
  output header_beat_s hdr,
  output logic break_grant,
  // Bench settings
  input wire logic [11:0] h1,
  input wire logic [11:0] h2,
  input wire logic grant_on
);
  // Processor side answers breaks at once unless told to stall
  assign break_grant = break_request & grant_on;
  // One header word, then an idle word that differs from it
  task automatic beat(input logic sec, input logic [11:0] w);
    repeat (2) @(posedge clk_sys);
    hdr <= '{valid: 1'b1, second: sec, word: w};
    @(posedge clk_sys);
    hdr <= '{valid: 1'b0, second: 1'b0, word: ~w};
  endtask
  // Seek, a wrong-sector pair first, then the wanted pair
  initial begin
    seek_done = 1'b0;
    hdr = '0;
    forever begin
      @(posedge clk_sys);
      #1;
      if (seek_start && !rst) begin
        repeat (3) @(posedge clk_sys);
        seek_done <= 1'b1;
        @(posedge clk_sys);
        seek_done <= 1'b0;
        beat(1'b0, h1 ^ 12'h001);
        beat(1'b1, h2);
        beat(1'b0, h1);
        beat(1'b1, h2);
      end
    end
  end
endmodule

// ==== test/disk_command_status_control_tb.sv ====
`timescale 1ns/1ps
module disk_command_status_control_tb import disk_ctl_pkg::*; ;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic clk_sys, rst, ce, iot_strobe, protect_switch, seek_done, seek_start, break_grant, break_request;
  logic accumulator_load, head_surface, ext_addr_bit2, track_half, write_gate, grant_on, seek_fault;
  logic [5:0] iot_code;
  logic [11:0] accumulator_in, accumulator_out, h1, h2, s, s2;
  logic [6:0] seek_track;
  logic [1:0] drive_select;
  logic [2:0] evt; // Read error, transfer end, next sector
  drive_state_s drives;
  header_beat_s hdr;
  int err_total, n_tests;
  // Short counts keep timeout runs brief
  disk_command_status_control #(.TIMEOUT_CYCLES(2000), .SECTOR_CYCLES(50)) i_dut (.clk_sys(clk_sys),
    .rst(rst), .ce(ce), .iot_strobe(iot_strobe), .iot_code(iot_code), .accumulator_in(accumulator_in),
    .accumulator_out(accumulator_out), .accumulator_load(accumulator_load), .drives(drives),
    .protect_switch(protect_switch), .seek_done(seek_done), .seek_fault(seek_fault), .seek_start(seek_start),
    .seek_track(seek_track), .drive_select(drive_select), .head_surface(head_surface),
    .ext_addr_bit2(ext_addr_bit2), .track_half(track_half), .hdr(hdr), .break_grant(break_grant),
    .read_error(evt[2]), .next_sector_req(evt[0]), .transfer_end(evt[1]), .break_request(break_request),
    .write_gate(write_gate));
  disk_drive_model i_drv (.clk_sys(clk_sys), .rst(rst), .seek_start(seek_start),
    .break_request(break_request), .seek_done(seek_done), .hdr(hdr), .break_grant(break_grant),
    .h1(h1), .h2(h2), .grant_on(grant_on));
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [11:0] exp, input logic [11:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One instruction, strobe high for one cycle
  task automatic iot(input logic [5:0] c, input logic [11:0] a);
    @(posedge clk_sys);
    iot_strobe <= 1'b1;
    iot_code <= c;
    accumulator_in <= a;
    @(posedge clk_sys);
    iot_strobe <= 1'b0;
  endtask
  // All-ones accumulator must not leak into the answer
  task automatic fetch(input logic [5:0] c, output logic [11:0] v);
    iot(c, 12'hfff);
    #1;
    chk("accumulator_load", 12'h001, {11'h0, accumulator_load});
    v = accumulator_out;
  endtask
  // Poll the busy bit, bounded
  task automatic wait_idle();
    s = 12'h800;
    for (int i = 0; i < 1200 && s[SB_BUSY] !== 1'b0; i++) fetch(IOT_FETCH_COND, s);
  endtask
  task automatic run(input string nm, input logic [11:0] ctl, input logic [5:0] c, input logic [11:0] ad,
      input logic [11:0] g1, input logic [11:0] g2, input logic [2:0] ev, input logic [11:0] exp);
    repeat (40) @(posedge clk_sys);
    iot(IOT_CLEAR_COND, 12'h000);
    iot(IOT_STORE_CTL, ctl);
    h1 = g1;
    h2 = g2;
    iot(c, ad);
    #1;
    if (!exp[SB_SELECT]) begin
      chk("seek_start", 12'h001, {11'h0, seek_start});
      chk("seek_track", {5'h0, ad[11:5]}, {5'h0, seek_track});
      chk("head_surface", {11'h0, ad[4]}, {11'h0, head_surface});
      fetch(IOT_FETCH_COND, s);
      chk("busy", 12'h001, {11'h0, s[SB_BUSY]});
    end
    // Wait for the transfer phase, then pulse the chosen event
    if (ev != 3'b000) begin
      for (int i = 0; i < 100 && break_request !== 1'b1; i++) @(posedge clk_sys);
      chk("write_gate", {11'h0, c == IOT_LOAD_WRITE}, {11'h0, write_gate});
      @(posedge clk_sys);
      evt <= ev;
      @(posedge clk_sys);
      evt <= 3'b000;
    end
    wait_idle();
    fetch(IOT_FETCH_COND, s);
    chk(nm, exp, s);
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic reg_fields();
    fetch(IOT_FETCH_CTL, s);
    chk("control reset", CW_RESET, s);
    fetch(IOT_FETCH_COND, s);
    chk("condition reset", COND_RESET, s);
    iot(IOT_STORE_CTL, 12'hd00);
    fetch(IOT_FETCH_CTL, s);
    chk("control word", 12'hd00, s);
    chk("drive_select", 12'h002, {10'h0, drive_select});
    chk("ext and half", 12'h003, {10'h0, ext_addr_bit2, track_half});
    // Enable low: a store must not land
    @(posedge clk_sys);
    ce <= 1'b0;
    iot(IOT_STORE_CTL, 12'h0ff);
    @(posedge clk_sys);
    ce <= 1'b1;
    fetch(IOT_FETCH_CTL, s);
    chk("frozen control", 12'hd00, s);
  endtask
  // Positioning error during the seek halts with select error
  task automatic seek_fail();
    repeat (40) @(posedge clk_sys);
    iot(IOT_CLEAR_COND, 12'h000);
    iot(IOT_STORE_CTL, 12'h200);
    iot(IOT_LOAD_READ, 12'h0a3);
    seek_fault <= 1'b1;
    @(posedge clk_sys);
    seek_fault <= 1'b0;
    wait_idle();
    fetch(IOT_FETCH_COND, s);
    chk("seek fault", 12'h403, s);
  endtask
  // Refused store while busy halts the write; clear then empties
  task automatic busy_clash();
    repeat (40) @(posedge clk_sys);
    iot(IOT_CLEAR_COND, 12'h000);
    iot(IOT_STORE_CTL, 12'h200);
    iot(IOT_LOAD_WRITE, 12'h0a3);
    iot(IOT_STORE_CTL, 12'h400);
    wait_idle();
    fetch(IOT_FETCH_COND, s);
    chk("busy clash", 12'h007, s);
    fetch(IOT_FETCH_CTL, s);
    chk("control kept", 12'h200, s);
    iot(IOT_CLEAR_COND, 12'h000);
    fetch(IOT_FETCH_COND, s);
    chk("cleared", 12'h000, s);
  endtask
  task automatic finish_test();
    $display("Comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // Clock, watchdog, main sequence
  // ------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (40000) @(posedge clk_sys);
    err_total++;
    finish_test();
  end
  initial begin
    {rst, ce, protect_switch, grant_on} = 4'hf;
    {iot_strobe, iot_code, accumulator_in, evt, h1, h2, seek_fault} = '0;
    drives = '{present: 4'h7, ready: 4'h7};
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    reg_fields();
    run("write", 12'h200, IOT_LOAD_WRITE, 12'h0a3, 12'h0a3, 12'h000, 3'b010, 12'h002);
    // Read twice one sector period apart: fields agree, sector steps once
    fetch(IOT_FETCH_POS, s);
    repeat (48) @(posedge clk_sys);
    fetch(IOT_FETCH_POS, s2);
    chk("position", 12'h00a, {4'h0, s[11:4]});
    chk("position again", 12'h00a, {4'h0, s2[11:4]});
    chk("sector step", {8'h0, s[3:0] + 4'h1}, {8'h0, s2[3:0]});
    run("track", 12'h200, IOT_LOAD_WRITE, 12'h0a3, 12'h0c3, 12'h000, 3'b000, 12'h043);
    run("lock", 12'h200, IOT_LOAD_WRITE, 12'h0a3, 12'h0a3, 12'h03f, 3'b000, 12'h103);
    run("bad write", 12'h200, IOT_LOAD_WRITE, 12'h0a3, 12'h0a3, 12'h03e, 3'b000, 12'h083);
    run("bad read", 12'h200, IOT_LOAD_READ, 12'h0a3, 12'h0a3, 12'h004, 3'b000, 12'h083);
    run("read", 12'h200, IOT_LOAD_READ, 12'h0a3, 12'h0a3, 12'hfc1, 3'b010, 12'h002);
    run("verify", 12'h200, IOT_LOAD_VERIFY, 12'h0a3, 12'h0a3, 12'h000, 3'b100, 12'h013);
    run("cap", 12'h200, IOT_LOAD_READ, 12'h0bf, 12'h0bf, 12'h000, 3'b001, 12'h203);
    run("seek", 12'h210, IOT_LOAD_READ, 12'h0a3, 12'h0a3, 12'h000, 3'b000, 12'h002);
    run("select", 12'h600, IOT_LOAD_READ, 12'h0a3, 12'h0a3, 12'h000, 3'b000, 12'h403);
    run("timeout", 12'h200, IOT_LOAD_WRITE, 12'h0a3, 12'h0a3, 12'h000, 3'b000, 12'h00b);
    grant_on = 1'b0;
    run("rate", 12'h200, IOT_LOAD_WRITE, 12'h0a3, 12'h0a3, 12'h000, 3'b000, 12'h023);
    grant_on = 1'b1;
    busy_clash();
    seek_fail();
    finish_test();
  end
endmodule
